// file: rtl/redriver_pkg.sv
// Constants, field layouts and state encoding of the redriver power control
package redriver_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ = 200;
   localparam int unsigned IDLE_TIME_MS = 300;
   localparam int unsigned IDLE_CYCLES = IDLE_TIME_MS * CLK_FREQ_MHZ * 1000;
   localparam int unsigned WAKE_TIME_US = 40;
   localparam int unsigned WAKE_CYCLES = WAKE_TIME_US * CLK_FREQ_MHZ;
   localparam int unsigned RESUME_TIME_US = 10;
   localparam int unsigned RESUME_CYCLES = RESUME_TIME_US * CLK_FREQ_MHZ;
   localparam int unsigned POLL_TIME_US = 100;
   localparam int unsigned POLL_CYCLES = POLL_TIME_US * CLK_FREQ_MHZ;

   // ----------------------------------------------------------------
   // Channels and configuration levels
   // ----------------------------------------------------------------
   localparam int NUM_CH = 2;
   localparam int LEVEL_W = 3;
   localparam int NUM_CFG = 7;
   localparam int CFG_W = LEVEL_W * NUM_CFG;
   localparam logic [LEVEL_W-1:0] LEVEL_MAX = 3'h4;
   localparam logic [LEVEL_W-1:0] LEVEL_OPEN = 3'h2;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h08;
   localparam int CTRL_W = 2;
   localparam int CTRL_SAVE_EN_BIT = 0;
   localparam int CTRL_POLL_EN_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_TERM_IND_BIT = 3;
   localparam int STAT_PRESENT_LSB = 4;
   localparam int STAT_ENABLE_BIT = 6;

   typedef enum logic [2:0] {
      ST_DEEP = 3'h0,
      ST_WAKE = 3'h1,
      ST_ACTIVE = 3'h3,
      ST_SAVE = 3'h2,
      ST_RESUME = 3'h6
   } pwr_state_type;

endpackage : redriver_pkg

// file: rtl/term_poll_if.sv
// Control link between the power sequencer and one termination poller
`timescale 1ns/10ps
`default_nettype none
interface term_poll_if;
   logic clear;
   logic run;
   logic assume_present;
   logic present;
   modport poller(input clear, input run, input assume_present, output present);
   modport ctrl(output clear, output run, output assume_present, input present);
endinterface : term_poll_if
`default_nettype wire

// file: rtl/term_poller.sv
// Periodic far-end receiver termination detection for one transmitter
`timescale 1ns/10ps
`default_nettype none
module term_poller
   import redriver_pkg::*;
#(
   parameter int unsigned POLL_CYC = POLL_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   term_poll_if.poller tp,
   output logic detect_req,
   input wire logic detect_done,
   input wire logic detect_found
);

   logic [31:0] cnt_q, cnt_d;
   logic req_q, req_d;
   logic busy_q, busy_d;
   logic present_q, present_d;

   // ----------------------------------------------------------------
   // Poll sequencing
   // ----------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      req_d = 1'b0;
      busy_d = busy_q;
      present_d = present_q;
      if (tp.clear) begin
         cnt_d = '0;
         busy_d = 1'b0;
         present_d = 1'b0;
      end else if (tp.assume_present) begin
         cnt_d = '0;
         busy_d = 1'b0;
         present_d = 1'b1;
      end else if (tp.run) begin
         if (busy_q) begin
            if (detect_done) begin
               present_d = detect_found;
               busy_d = 1'b0;
            end
         end else if (cnt_q == 32'(POLL_CYC - 1)) begin
            cnt_d = '0;
            req_d = 1'b1;
            busy_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 32'h1;
         end
      end else begin
         cnt_d = '0;
         busy_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         req_q <= 1'b0;
         busy_q <= 1'b0;
         present_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         req_q <= req_d;
         busy_q <= busy_d;
         present_q <= present_d;
      end
   end

   assign detect_req = req_q;
   assign tp.present = present_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_req_single_pulse: assert property (detect_req |=> !detect_req)
      else $error("Detection request longer than one cycle");
   a_req_only_polling: assert property (detect_req |-> $past(tp.run))
      else $error("Detection request outside polling");

endmodule : term_poller
`default_nettype wire

// file: rtl/redriver_power_ctrl.sv
// Power-on initialization, enable handling and power states of a two-channel redriver
//
// Overview of operation
// - Power-on reset initializes all state machines and loads register defaults.
// - The enable pin may change at any time, unrelated to the clock.
// - Enable high means Active state; enable low means Deep power-saving.
// - Configuration pins are sampled at power-on and on every enable change.
// - A rising enable edge repeats the full power-on initialization.
// - Power state follows bus electrical conditions, pins and registers only.
// - Active: both channels pass data, termination indicated, detection idle.
// - Power-saving: channels on, squelch, LFPS and termination detection active.
// - Power-saving without connection: poll termination, indication deasserted.
// - Power-saving with connection in U2/U3: poll termination, indication asserted.
// - Deep power-saving: terminations high impedance, common mode not held.
// - Deep to Active waits several tens of microseconds before being active.
// - Each transmitter detects a far-end termination load.
// - Electrical idle must last about 300 ms before Power-saving is entered.
// - Power-saving returns to Active in typically 10 microseconds.
// - New configuration settings apply within 100 microseconds.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module redriver_power_ctrl
   import redriver_pkg::*;
#(
   parameter int unsigned IDLE_CYC = IDLE_CYCLES,
   parameter int unsigned WAKE_CYC = WAKE_CYCLES,
   parameter int unsigned POLL_CYC = POLL_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chip_enable_pin,
   input wire logic [LEVEL_W-1:0] port_a_equalization_pin,
   input wire logic [LEVEL_W-1:0] port_b_equalization_pin,
   input wire logic [LEVEL_W-1:0] port_a_deemphasis_pin,
   input wire logic [LEVEL_W-1:0] port_b_deemphasis_pin,
   input wire logic [LEVEL_W-1:0] port_a_output_swing_pin,
   input wire logic [LEVEL_W-1:0] port_b_output_swing_pin,
   input wire logic [LEVEL_W-1:0] squelch_threshold_pin,
   input wire logic elec_idle,
   input wire logic lfps_detect,
   input wire logic [NUM_CH-1:0] term_detect_done,
   input wire logic [NUM_CH-1:0] term_detect_found,
   output logic [NUM_CH-1:0] term_detect_req,
   output logic [CFG_W-1:0] config_setting,
   output logic [NUM_CH-1:0] chan_enable,
   output logic squelch_lfps_enable,
   output logic term_indication,
   output logic term_hiz,
   output logic cm_hold,
   output logic device_active
);

   localparam logic [31:0] RESUME_LAST = 32'(RESUME_CYCLES - 1);

   function automatic logic [LEVEL_W-1:0] level_clamp(input logic [LEVEL_W-1:0] lvl);
      level_clamp = (lvl > LEVEL_MAX) ? LEVEL_OPEN : lvl;
   endfunction : level_clamp

   // ----------------------------------------------------------------
   // Enable synchronizer and edge detection
   // ----------------------------------------------------------------
   logic en_meta_q, en_sync_q, en_prev_q;
   logic en_rise, en_edge;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
         en_prev_q <= 1'b0;
      end else begin
         en_meta_q <= chip_enable_pin;
         en_sync_q <= en_meta_q;
         en_prev_q <= en_sync_q;
      end
   end

   assign en_rise = en_sync_q & ~en_prev_q;
   assign en_edge = en_sync_q ^ en_prev_q;

   // ----------------------------------------------------------------
   // Configuration sampling
   // ----------------------------------------------------------------
   logic [CFG_W-1:0] cfg_q, cfg_d, cfg_pins;
   logic loaded_q, loaded_d;

   assign cfg_pins = {level_clamp(squelch_threshold_pin),
                      level_clamp(port_b_output_swing_pin),
                      level_clamp(port_a_output_swing_pin),
                      level_clamp(port_b_deemphasis_pin),
                      level_clamp(port_a_deemphasis_pin),
                      level_clamp(port_b_equalization_pin),
                      level_clamp(port_a_equalization_pin)};

   always_comb begin
      cfg_d = cfg_q;
      loaded_d = 1'b1;
      if (!loaded_q || en_edge) begin
         cfg_d = cfg_pins;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_q <= '0;
         loaded_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         loaded_q <= loaded_d;
      end
   end

   assign config_setting = cfg_q;

   // ----------------------------------------------------------------
   // Termination pollers
   // ----------------------------------------------------------------
   pwr_state_type state_q, state_d;
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [NUM_CH-1:0] present;
   logic any_present;

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : gen_ch
      term_poll_if tp ();
      assign tp.clear = en_rise | ~en_sync_q;
      assign tp.run = (state_q == ST_SAVE) & ctrl_q[CTRL_POLL_EN_BIT];
      assign tp.assume_present = (state_q == ST_ACTIVE);
      assign present[ch] = tp.present;
      term_poller #(
         .POLL_CYC(POLL_CYC)
      ) u_poller (
         .core_clk(core_clk),
         .rst(rst),
         .tp(tp.poller),
         .detect_req(term_detect_req[ch]),
         .detect_done(term_detect_done[ch]),
         .detect_found(term_detect_found[ch])
      );
   end

   assign any_present = |present;

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   logic [31:0] timer_q, timer_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_DEEP: begin
            state_d = ST_WAKE;
         end
         ST_WAKE: begin
            if (timer_q == 32'(WAKE_CYC - 1)) begin
               state_d = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (ctrl_q[CTRL_SAVE_EN_BIT] && elec_idle && timer_q == 32'(IDLE_CYC - 1)) begin
               state_d = ST_SAVE;
            end
         end
         ST_SAVE: begin
            if (lfps_detect || !elec_idle) begin
               state_d = ST_RESUME;
            end
         end
         ST_RESUME: begin
            if (timer_q == RESUME_LAST) begin
               state_d = ST_ACTIVE;
            end
         end
         default: begin
            state_d = ST_DEEP;
         end
      endcase
      if (!en_sync_q || en_rise) begin
         state_d = ST_DEEP;
      end
      timer_d = timer_q + 32'h1;
      if (state_d != state_q) begin
         timer_d = '0;
      end else if (state_q == ST_ACTIVE) begin
         if (!elec_idle) begin
            timer_d = '0;
         end else if (timer_q == 32'(IDLE_CYC - 1)) begin
            timer_d = timer_q;
         end
      end else if (state_q == ST_SAVE || state_q == ST_DEEP) begin
         timer_d = '0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_DEEP;
         timer_q <= '0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
      end
   end

   // ----------------------------------------------------------------
   // Analog controls
   // ----------------------------------------------------------------
   logic [NUM_CH-1:0] chan_q, chan_d;
   logic sq_q, sq_d, ind_q, ind_d, hiz_q, hiz_d, cm_q, cm_d, act_q, act_d;

   always_comb begin
      act_d = (state_d == ST_ACTIVE);
      chan_d = (state_d == ST_DEEP || state_d == ST_WAKE) ? '0 : '1;
      sq_d = (state_d == ST_SAVE);
      hiz_d = (state_d == ST_DEEP);
      cm_d = (state_d != ST_DEEP);
      case (state_d)
         ST_ACTIVE, ST_RESUME: ind_d = 1'b1;
         ST_SAVE: ind_d = any_present;
         default: ind_d = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         chan_q <= '0;
         sq_q <= 1'b0;
         ind_q <= 1'b0;
         hiz_q <= 1'b1;
         cm_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         chan_q <= chan_d;
         sq_q <= sq_d;
         ind_q <= ind_d;
         hiz_q <= hiz_d;
         cm_q <= cm_d;
         act_q <= act_d;
      end
   end

   assign chan_enable = chan_q;
   assign squelch_lfps_enable = sq_q;
   assign term_indication = ind_q;
   assign term_hiz = hiz_q;
   assign cm_hold = cm_q;
   assign device_active = act_q;

   // ----------------------------------------------------------------
   // APB register slave
   // ----------------------------------------------------------------
   logic [31:0] rdata_q, rdata_d;
   logic err_q, err_d;
   logic setup, wr_access;

   assign setup = psel & ~penable;
   assign wr_access = psel & penable & pwrite;

   always_comb begin
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      err_d = 1'b0;
      if (wr_access && paddr == CTRL_OFS) begin
         ctrl_d = pwdata[CTRL_W-1:0];
      end
      if (setup) begin
         rdata_d = '0;
         case (paddr)
            CTRL_OFS: rdata_d[CTRL_W-1:0] = ctrl_q;
            STATUS_OFS: begin
               rdata_d[STAT_STATE_LSB +: 3] = state_q;
               rdata_d[STAT_TERM_IND_BIT] = ind_q;
               rdata_d[STAT_PRESENT_LSB +: NUM_CH] = present;
               rdata_d[STAT_ENABLE_BIT] = en_sync_q;
            end
            CONFIG_OFS: rdata_d[CFG_W-1:0] = cfg_q;
            default: err_d = 1'b1;
         endcase
      end else if (penable) begin
         err_d = err_q;
      end
      if (en_rise) begin
         ctrl_d = CTRL_RST;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         rdata_q <= '0;
         err_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
      end
   end

   assign prdata = rdata_q;
   assign pready = psel & penable;
   assign pslverr = err_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_enable_sync_lag: assert property (!$past(rst, 2) |-> en_sync_q == $past(chip_enable_pin, 2))
      else $error("Enable synchronizer is not two stages");
   a_deep_when_low: assert property (!en_sync_q |=> state_q == ST_DEEP)
      else $error("Not in deep power-saving with enable low");
   a_rise_reinit: assert property (en_rise |=> state_q == ST_DEEP && ctrl_q == CTRL_RST)
      else $error("Enable rise did not reinitialize");
   a_cfg_resample: assert property (en_edge |=> cfg_q == $past(cfg_pins))
      else $error("Configuration not sampled on enable change");
   a_active_term_ind: assert property (state_q == ST_ACTIVE |-> ind_q && chan_q == '1
      && term_detect_req == '0 && act_q)
      else $error("Active state outputs wrong");
   a_save_channels_on: assert property (state_q == ST_SAVE |-> chan_q == '1 && sq_q)
      else $error("Power-saving outputs wrong");
   a_save_no_conn: assert property (state_q == ST_SAVE && !$past(any_present) |-> !ind_q)
      else $error("Indication asserted without connection");
   a_save_conn_ind: assert property (state_q == ST_SAVE && $past(any_present) |-> ind_q)
      else $error("Indication dropped with connection");
   a_deep_hiz: assert property (state_q == ST_DEEP |-> hiz_q && !cm_q && chan_q == '0)
      else $error("Deep power-saving outputs wrong");
   a_wake_wait: assert property (state_q == ST_WAKE && en_sync_q && !en_rise
      && timer_q < 32'(WAKE_CYC - 1) |=> state_q == ST_WAKE)
      else $error("Wake interval cut short");
   a_idle_hold: assert property (state_q == ST_ACTIVE && timer_q < 32'(IDLE_CYC - 1)
      |=> state_q != ST_SAVE)
      else $error("Power-saving entered before idle interval");
   a_resume_time: assert property (state_q == ST_RESUME && timer_q == RESUME_LAST
      && en_sync_q && !en_rise |=> state_q == ST_ACTIVE)
      else $error("Resume did not finish on time");
   a_save_exit: assert property (state_q == ST_SAVE && en_sync_q && !en_rise
      && (lfps_detect || !elec_idle) |=> state_q == ST_RESUME)
      else $error("Power-saving exit missed");

   c_reach_active: cover property (state_q == ST_WAKE ##1 state_q == ST_ACTIVE);
   c_enter_save: cover property (state_q == ST_ACTIVE ##1 state_q == ST_SAVE);
   c_resume_active: cover property (state_q == ST_RESUME ##1 state_q == ST_ACTIVE);
   c_enable_rise: cover property (en_rise);

endmodule : redriver_power_ctrl
`default_nettype wire

// file: tb/link_partner_model.sv
// Far-end receiver loads and detector timing for both channels
`timescale 1ns/10ps
`default_nettype none
module link_partner_model
   import redriver_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [NUM_CH-1:0] term_detect_req,
   input wire logic [NUM_CH-1:0] load_present,
   input wire logic slow,
   output logic [NUM_CH-1:0] term_detect_done,
   output logic [NUM_CH-1:0] term_detect_found
);
   int cnt [NUM_CH];
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt <= '{default: 0};
         term_detect_done <= '0;
         term_detect_found <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (term_detect_req[c])
               cnt[c] <= slow ? 6 : 2;
            else if (cnt[c] > 0)
               cnt[c] <= cnt[c] - 1;
            term_detect_done[c] <= (cnt[c] == 1);
            // Result only valid with done, otherwise it wanders
            if (cnt[c] == 1)
               term_detect_found[c] <= load_present[c];
            else
               term_detect_found[c] <= ~term_detect_found[c];
         end
      end
   end
endmodule : link_partner_model
`default_nettype wire

// file: tb/redriver_power_state_control_tb.sv
// Self-checking bench for the redriver power control
`timescale 1ns/10ps
`default_nettype none
module redriver_power_state_control_tb
   import redriver_pkg::*;
;
   localparam int IDLE_N = 50;
   localparam int POLL_N = 10;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic chip_enable_pin = 1'h1;
   logic [LEVEL_W-1:0] cfg [NUM_CFG] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1, 3'h3};
   logic elec_idle = 1'h0, lfps_detect = 1'h0, slow = 1'h0;
   logic [NUM_CH-1:0] load_present = 2'h0;
   logic [NUM_CH-1:0] done, found, req, chan_enable;
   logic [CFG_W-1:0] config_setting;
   logic squelch_lfps_enable, term_indication, term_hiz, cm_hold, device_active;
   logic [6:0] pins;
   int n_mismatch = 0, compares = 0, n_req = 0;

   assign pins = {chan_enable, squelch_lfps_enable, term_indication, term_hiz, cm_hold,
      device_active};
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) if (|req) n_req <= n_req + 1;

   redriver_power_ctrl #(.IDLE_CYC(IDLE_N), .WAKE_CYC(20), .POLL_CYC(POLL_N)) DUT (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chip_enable_pin(chip_enable_pin), .port_a_equalization_pin(cfg[0]),
      .port_b_equalization_pin(cfg[1]), .port_a_deemphasis_pin(cfg[2]),
      .port_b_deemphasis_pin(cfg[3]), .port_a_output_swing_pin(cfg[4]),
      .port_b_output_swing_pin(cfg[5]), .squelch_threshold_pin(cfg[6]),
      .elec_idle(elec_idle), .lfps_detect(lfps_detect), .term_detect_done(done),
      .term_detect_found(found), .term_detect_req(req), .config_setting(config_setting),
      .chan_enable(chan_enable), .squelch_lfps_enable(squelch_lfps_enable),
      .term_indication(term_indication), .term_hiz(term_hiz), .cm_hold(cm_hold),
      .device_active(device_active));

   link_partner_model partner (.core_clk(core_clk), .rst(rst), .term_detect_req(req),
      .load_present(load_present), .slow(slow), .term_detect_done(done),
      .term_detect_found(found));

   // ----------------------------------------------------------------
   // Bus tasks and checks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1) begin
         @(posedge core_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      check("read", rd, exp);
   endtask : rd_chk

   task automatic wait_state(input logic [2:0] st, input int lim);
      int n;
      n = 0;
      do begin
         apb(1'h0, STATUS_OFS, 32'h0);
         n++;
      end while (rd[2:0] !== st && n < lim);
      check("state", 32'(rd[2:0]), 32'(st));
   endtask : wait_state

   function automatic logic [CFG_W-1:0] exp_cfg();
      logic [CFG_W-1:0] v;
      for (int i = 0; i < NUM_CFG; i++)
         v[i*LEVEL_W +: LEVEL_W] = (cfg[i] > LEVEL_MAX) ? LEVEL_OPEN : cfg[i];
      return v;
   endfunction : exp_cfg

   task automatic give_verdict();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(negedge core_clk);
      check("reset_pins", 32'(pins), 32'h04);
      repeat (9) @(posedge core_clk);
      rst <= 1'h0;
      repeat (10) @(negedge core_clk);
      check("early", 32'(device_active), 32'h0);
      rd_chk(CTRL_OFS, 32'h3);
      wait_state(ST_ACTIVE, 40);
      @(negedge core_clk);
      check("active", 32'(pins), 32'h6b);
      check("cfg", 32'(config_setting), 32'(exp_cfg()));
      rd_chk(CONFIG_OFS, 32'(exp_cfg()));
      $display("test power_on done");
      apb(1'h1, CTRL_OFS, 32'h2);
      apb(1'h1, STATUS_OFS, 32'hffffffff);
      elec_idle <= 1'h1;
      apb(1'h0, 8'h0c, 32'h0);
      check("unmapped", 32'(err), 32'h1);
      repeat (2 * IDLE_N) @(posedge core_clk);
      rd_chk(STATUS_OFS, 32'h7b);
      rd_chk(CTRL_OFS, 32'h2);
      $display("test registers done");
      apb(1'h1, CTRL_OFS, 32'h3);
      elec_idle <= 1'h0;
      @(posedge core_clk);
      elec_idle <= 1'h1;
      repeat (IDLE_N - 10) @(negedge core_clk);
      check("idle_wait", 32'(squelch_lfps_enable), 32'h0);
      wait_state(ST_SAVE, 10);
      @(negedge core_clk);
      check("save", 32'(pins[6:4]), 32'h7);
      repeat (4 * POLL_N) @(negedge core_clk);
      check("no_conn", 32'(term_indication), 32'h0);
      check("polled", 32'(n_req != 0), 32'h1);
      load_present <= 2'h3;
      slow <= 1'h1;
      repeat (6 * POLL_N) @(negedge core_clk);
      check("conn", 32'(term_indication), 32'h1);
      rd_chk(STATUS_OFS, 32'h7a);
      $display("test power_saving done");
      lfps_detect <= 1'h1;
      @(posedge core_clk);
      lfps_detect <= 1'h0;
      elec_idle <= 1'h0;
      wait_state(ST_RESUME, 3);
      repeat (1900) @(posedge core_clk);
      wait_state(ST_RESUME, 1);
      wait_state(ST_ACTIVE, 60);
      $display("test resume done");
      cfg <= '{3'h4, 3'h0, 3'h3, 3'h1, 3'h2, 3'h4, 3'h0};
      repeat (2) @(posedge core_clk);
      chip_enable_pin <= 1'h0;
      @(negedge core_clk);
      check("sync", 32'(device_active), 32'h1);
      repeat (5) @(negedge core_clk);
      check("off", 32'(device_active), 32'h0);
      check("deep", 32'(pins), 32'h04);
      check("cfg_fall", 32'(config_setting), 32'(exp_cfg()));
      apb(1'h1, CTRL_OFS, 32'h0);
      cfg <= '{3'h7, 3'h5, 3'h6, 3'h0, 3'h1, 3'h2, 3'h3};
      @(posedge core_clk);
      chip_enable_pin <= 1'h1;
      repeat (5) @(negedge core_clk);
      check("cfg_rise", 32'(config_setting), 32'(exp_cfg()));
      rd_chk(CTRL_OFS, 32'h3);
      wait_state(ST_ACTIVE, 20);
      $display("test enable done");
      give_verdict();
   end

   initial begin
      repeat (8000) @(posedge core_clk);
      n_mismatch++;
      give_verdict();
   end
endmodule : redriver_power_state_control_tb
`default_nettype wire
